// >>> dv/iep_asserts.sv
`timescale 1ns/100ps
module iep_asserts (
    input wire logic       sys_clk,
    input wire logic       resetn,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_write,
    input wire logic       reg_read,
    input wire logic [7:0] reg_rdata,
    input wire logic [5:0] source_request,
    input wire logic       core_irq_valid,
    input wire logic [2:0] core_irq_source,
    input wire logic [1:0] core_irq_level
);
    logic [7:0] en_shadow;
    logic [7:0] ph;
    logic [7:0] pl;
    logic       ev;
    logic [2:0] exp_src;
    logic [1:0] el;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    // shadow copies of the registers, reserved bits masked off
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            en_shadow <= 8'h00;
            ph <= 8'h00;
            pl <= 8'h00;
        end else if (reg_write) begin
            if (reg_addr == 8'hA8) en_shadow <= reg_wdata & 8'hBF;
            if (reg_addr == 8'hB7) ph <= reg_wdata & 8'h3F;
            if (reg_addr == 8'hB8) pl <= reg_wdata & 8'h3F;
        end
    end
    // expected winner; scan downwards so ties go to the lower index
    always_comb begin
        ev = 1'b0;
        exp_src = 3'h0;
        el = 2'h0;
        for (int i = 5; i >= 0; i--) begin
            if (source_request[i] && en_shadow[i] && en_shadow[7] &&
                (!ev || {ph[i], pl[i]} >= el)) begin
                ev = 1'b1;
                exp_src = 3'(i);
                el = {ph[i], pl[i]};
            end
        end
    end
    AST_VALID: assert property (core_irq_valid == $past(ev))
        else $error("valid does not follow enabled requests");
    AST_WINNER: assert property (core_irq_valid |->
        core_irq_source == $past(exp_src) && core_irq_level == $past(el))
        else $error("wrong winner or level");
    AST_IDLE: assert property (!core_irq_valid |->
        core_irq_source == 3'h0 && core_irq_level == 2'h0)
        else $error("winner fields not zero while idle");
    AST_GLOBAL: assert property (!$past(en_shadow[7]) |->
        !core_irq_valid)
        else $error("request passed with global enable off");
    AST_RD_IDLE: assert property (!$past(reg_read) |-> reg_rdata == 8'h00)
        else $error("read data not zero outside read cycle");
    AST_RD_IE: assert property ($past(reg_read && reg_addr == 8'hA8) |->
        reg_rdata == $past(en_shadow))
        else $error("enable register read wrong");
    AST_RD_PH: assert property ($past(reg_read && reg_addr == 8'hB7) |->
        reg_rdata == $past(ph)) else $error("high level register read wrong");
    AST_RD_PL: assert property ($past(reg_read && reg_addr == 8'hB8) |->
        reg_rdata == $past(pl)) else $error("low level register read wrong");
endmodule : iep_asserts
bind iep_top iep_asserts iep_asserts_inst (.sys_clk, .resetn, .reg_addr,
    .reg_wdata, .reg_write, .reg_read, .reg_rdata, .source_request,
    .core_irq_valid, .core_irq_source, .core_irq_level);

// >>> dv/iep_src_model.sv
`timescale 1ns/100ps
// peripheral request lines, each held high until told to drop
module iep_src_model (
    input  wire logic       sys_clk,
    input  wire logic       resetn,
    input  wire logic [5:0] pattern,
    output logic      [5:0] source_request
);
    // registered so requests move just after the clock edge
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            source_request <= 6'h00;
        end else begin
            source_request <= pattern;
        end
    end
endmodule : iep_src_model

// >>> dv/tb_interrupt_enable_priority.sv
`timescale 1ns/100ps
module tb_interrupt_enable_priority;
    logic sys_clk = 0, resetn = 0, reg_write = 0, reg_read = 0;
    logic core_irq_valid, irq;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
    logic [5:0] pattern = 6'h00, source_request;
    logic [2:0] core_irq_source;
    logic [1:0] core_irq_level;
    int miscompares = 0, checks = 0;
    // 20 MHz core clock
    always #25 sys_clk = ~sys_clk;
    iep_src_model iep_src_model_inst (.sys_clk(sys_clk), .resetn(resetn),
        .pattern(pattern), .source_request(source_request));
    iep_top iep_top_inst (.sys_clk(sys_clk), .resetn(resetn),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
        .reg_read(reg_read), .reg_rdata(reg_rdata),
        .source_request(source_request), .core_irq_valid(core_irq_valid),
        .core_irq_source(core_irq_source), .core_irq_level(core_irq_level),
        .irq(irq));
    task automatic cmp(input string n, input logic [7:0] e, s);
        checks++;
        if (s !== e) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask : cmp
    task automatic wr(input logic [7:0] a, d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge sys_clk);
        reg_write <= 1'b0;
        @(negedge sys_clk);
    endtask : wr
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, e);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge sys_clk);
        reg_read <= 1'b0;
        @(negedge sys_clk);
        cmp("rdata", e, reg_rdata);
    endtask : rd
    // request passes the source model, then one registered stage
    task automatic chk(input logic v, input logic [2:0] s, input logic [1:0] l);
        repeat (3) @(posedge sys_clk);
        @(negedge sys_clk);
        cmp("valid", {7'h00, v}, {7'h00, core_irq_valid});
        cmp("source", {5'h00, s}, {5'h00, core_irq_source});
        cmp("level", {6'h00, l}, {6'h00, core_irq_level});
    endtask : chk
    task automatic end_of_test();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : end_of_test
    // main sequence
    initial begin
        repeat (12) @(posedge sys_clk);
        resetn <= 1'b1;
        rd(8'hA8, 8'h00);
        wr(8'hA8, 8'hFF);
        rd(8'hA8, 8'hBF);
        rd(8'h10, 8'h00);
        pattern <= 6'h3F;
        for (int i = 0; i < 6; i++) begin
            wr(8'hA8, 8'h80 | (8'h01 << i));
            chk(1'b1, 3'(i), 2'h0);
        end
        wr(8'hA8, 8'h3F);
        chk(1'b0, 3'h0, 2'h0);
        wr(8'hA8, 8'hBF);
        chk(1'b1, 3'h0, 2'h0);
        wr(8'hB7, 8'h20);
        chk(1'b1, 3'h5, 2'h2);
        wr(8'hB8, 8'h08);
        wr(8'hB7, 8'hE8);
        chk(1'b1, 3'h3, 2'h3);
        rd(8'hB7, 8'h28);
        pattern <= 6'h00;
        wr(8'hC1, 8'h03);
        wr(8'hC2, 8'h01);
        chk(1'b0, 3'h0, 2'h0);
        cmp("irq", 8'h00, {7'h00, irq});
        pattern <= 6'h01;
        chk(1'b1, 3'h0, 2'h0);
        cmp("irq", 8'h01, {7'h00, irq});
        wr(8'hC2, 8'h00);
        cmp("irq", 8'h00, {7'h00, irq});
        wr(8'hC2, 8'h01);
        cmp("irq", 8'h01, {7'h00, irq});
        wr(8'hC1, 8'h01);
        cmp("irq", 8'h00, {7'h00, irq});
        end_of_test();
    end
endmodule : tb_interrupt_enable_priority

// >>> logic/iep_arbiter.sv
`timescale 1ns/100ps
// picks the winning source: level first, polling order second
module iep_arbiter #(
    parameter int N = 6
) (
    input  wire logic [N-1:0] request,
    input  wire logic [N-1:0] level_high,
    input  wire logic [N-1:0] level_low,
    output logic              valid,
    output logic [2:0]        winner,
    output logic [1:0]        winner_level
);
    // scan levels from 3 down; lower index wins a tie by polling order
    always_comb begin
        valid        = 1'b0;
        winner       = 3'h0;
        winner_level = 2'h0;
        for (int lv = 3; lv >= 0; lv--) begin
            for (int s = N - 1; s >= 0; s--) begin
                if (!valid && request[s] &&
                    {level_high[s], level_low[s]} == 2'(lv)) begin
                    winner       = 3'(s);
                    winner_level = 2'(lv);
                end
            end
            if (!valid) begin
                for (int s = 0; s < N; s++) begin
                    if (request[s] &&
                        {level_high[s], level_low[s]} == 2'(lv)) begin
                        valid = 1'b1;
                    end
                end
            end
        end
    end
endmodule : iep_arbiter

// >>> logic/iep_pkg.sv
package iep_pkg;
    // register addresses (byte addresses on the plain register port)
    localparam logic [7:0] ADDR_INTERRUPT_ENABLE  = 8'hA8;
    localparam logic [7:0] ADDR_PRIORITY_HIGH     = 8'hB7;
    localparam logic [7:0] ADDR_PRIORITY_LOW      = 8'hB8;
    localparam logic [7:0] ADDR_EVENT_STATUS      = 8'hC0;
    localparam logic [7:0] ADDR_EVENT_CLEAR       = 8'hC1;
    localparam logic [7:0] ADDR_EVENT_ENABLE      = 8'hC2;
    localparam logic [7:0] ADDR_SERVICE           = 8'hC3;

    // interrupt enable field positions
    localparam int BIT_EXT_INPUT0_IRQ_ENABLE = 0;
    localparam int BIT_TIMER0_IRQ_ENABLE     = 1;
    localparam int BIT_EXT_INPUT1_IRQ_ENABLE = 2;
    localparam int BIT_TIMER1_IRQ_ENABLE     = 3;
    localparam int BIT_SERIAL_IRQ_ENABLE     = 4;
    localparam int BIT_TIMER2_IRQ_ENABLE     = 5;
    localparam int BIT_RESERVED              = 6;
    localparam int BIT_GLOBAL_IRQ_ENABLE     = 7;

    // writable masks and reset values
    localparam logic [7:0] ENABLE_WRITE_MASK   = 8'hBF;
    localparam logic [7:0] LEVEL_WRITE_MASK    = 8'h3F;
    localparam logic [7:0] RESET_ENABLE        = 8'h00;
    localparam logic [7:0] RESET_LEVEL         = 8'h00;
    localparam logic [1:0] RESET_EVENT         = 2'h0;

    // event status bit positions
    localparam int EVT_NEW_REQUEST = 0;
    localparam int EVT_OVERRIDE    = 1;

    localparam int NUM_SOURCES = 6;
endpackage : iep_pkg

// >>> logic/iep_top.sv
// The address-and-strobe port was left to the implementer.
`timescale 1ns/100ps
module iep_top (
    input  wire logic       sys_clk,
    input  wire logic       resetn,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_write,
    input  wire logic       reg_read,
    output logic      [7:0] reg_rdata,
    input  wire logic [5:0] source_request,
    output logic            core_irq_valid,
    output logic      [2:0] core_irq_source,
    output logic      [1:0] core_irq_level,
    output logic            irq
);
    localparam int N = iep_pkg::NUM_SOURCES;

    logic [7:0] interrupt_enable;
    logic [7:0] interrupt_priority_high;
    logic [7:0] interrupt_priority_low;
    logic [1:0] event_status;
    logic [1:0] event_enable;
    logic [7:0] reg_rdata_q;
    logic       core_irq_valid_q;
    logic [2:0] core_irq_source_q;
    logic [1:0] core_irq_level_q;

    logic [7:0] next_interrupt_enable;
    logic [7:0] next_interrupt_priority_high;
    logic [7:0] next_interrupt_priority_low;
    logic [1:0] next_event_status;
    logic [1:0] next_event_enable;
    logic [7:0] next_reg_rdata;
    logic       next_core_irq_valid;
    logic [2:0] next_core_irq_source;
    logic [1:0] next_core_irq_level;

    logic [N-1:0] gated_request;
    logic         arb_valid;
    logic [2:0]   arb_winner;
    logic [1:0]   arb_level;
    logic [1:0]   event_set;
    logic [1:0]   event_clear;

    // a write lands only on an exact address match
    function automatic logic hit(input logic [7:0] addr,
                                 input logic [7:0] target);
        hit = (addr == target);
    endfunction : hit

    always_comb begin
        gated_request = source_request &
            interrupt_enable[N-1:0] &
            {N{interrupt_enable[iep_pkg::BIT_GLOBAL_IRQ_ENABLE]}};
    end

    iep_arbiter #(
        .N (N)
    ) u_arbiter (
        .request      (gated_request),
        .level_high   (interrupt_priority_high[N-1:0]),
        .level_low    (interrupt_priority_low[N-1:0]),
        .valid        (arb_valid),
        .winner       (arb_winner),
        .winner_level (arb_level)
    );

    // events: a new winner appears, or a higher level pre-empts the winner
    always_comb begin
        event_set = 2'h0;
        event_set[iep_pkg::EVT_NEW_REQUEST] = arb_valid && !core_irq_valid_q;
        event_set[iep_pkg::EVT_OVERRIDE] = arb_valid && core_irq_valid_q &&
            (arb_level > core_irq_level_q);
        event_clear = 2'h0;
        if (reg_write && hit(reg_addr, iep_pkg::ADDR_EVENT_CLEAR)) begin
            event_clear = reg_wdata[1:0];
        end
    end

    // register next values; set beats clear so no event is lost
    always_comb begin
        next_interrupt_enable        = interrupt_enable;
        next_interrupt_priority_high = interrupt_priority_high;
        next_interrupt_priority_low  = interrupt_priority_low;
        next_event_enable            = event_enable;
        next_event_status = (event_status & ~event_clear) | event_set;
        if (reg_write) begin
            if (hit(reg_addr, iep_pkg::ADDR_INTERRUPT_ENABLE)) begin
                next_interrupt_enable =
                    reg_wdata & iep_pkg::ENABLE_WRITE_MASK;
            end
            if (hit(reg_addr, iep_pkg::ADDR_PRIORITY_HIGH)) begin
                next_interrupt_priority_high =
                    reg_wdata & iep_pkg::LEVEL_WRITE_MASK;
            end
            if (hit(reg_addr, iep_pkg::ADDR_PRIORITY_LOW)) begin
                next_interrupt_priority_low =
                    reg_wdata & iep_pkg::LEVEL_WRITE_MASK;
            end
            if (hit(reg_addr, iep_pkg::ADDR_EVENT_ENABLE)) begin
                next_event_enable = reg_wdata[1:0];
            end
        end
    end

    // read mux; unmapped addresses and write-only clear read zero
    always_comb begin
        next_reg_rdata = 8'h00;
        if (reg_read) begin
            unique case (reg_addr)
                iep_pkg::ADDR_INTERRUPT_ENABLE:
                    next_reg_rdata = interrupt_enable;
                iep_pkg::ADDR_PRIORITY_HIGH:
                    next_reg_rdata = interrupt_priority_high;
                iep_pkg::ADDR_PRIORITY_LOW:
                    next_reg_rdata = interrupt_priority_low;
                iep_pkg::ADDR_EVENT_STATUS:
                    next_reg_rdata = {6'h00, event_status};
                iep_pkg::ADDR_EVENT_ENABLE:
                    next_reg_rdata = {6'h00, event_enable};
                iep_pkg::ADDR_SERVICE:
                    next_reg_rdata = {core_irq_valid_q, 2'h0,
                                      core_irq_level_q, core_irq_source_q};
                default:
                    next_reg_rdata = 8'h00;
            endcase
        end
    end

    // the core sees the winner one cycle later, from flip-flops
    always_comb begin
        next_core_irq_valid  = arb_valid;
        next_core_irq_source = arb_valid ? arb_winner : 3'h0;
        next_core_irq_level  = arb_valid ? arb_level : 2'h0;
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            interrupt_enable        <= iep_pkg::RESET_ENABLE;
            interrupt_priority_high <= iep_pkg::RESET_LEVEL;
            interrupt_priority_low  <= iep_pkg::RESET_LEVEL;
            event_status            <= iep_pkg::RESET_EVENT;
            event_enable            <= iep_pkg::RESET_EVENT;
            reg_rdata_q             <= 8'h00;
            core_irq_valid_q        <= 1'b0;
            core_irq_source_q       <= 3'h0;
            core_irq_level_q        <= 2'h0;
        end else begin
            interrupt_enable        <= next_interrupt_enable;
            interrupt_priority_high <= next_interrupt_priority_high;
            interrupt_priority_low  <= next_interrupt_priority_low;
            event_status            <= next_event_status;
            event_enable            <= next_event_enable;
            reg_rdata_q             <= next_reg_rdata;
            core_irq_valid_q        <= next_core_irq_valid;
            core_irq_source_q       <= next_core_irq_source;
            core_irq_level_q        <= next_core_irq_level;
        end
    end

    // outputs
    assign reg_rdata       = reg_rdata_q;
    assign core_irq_valid  = core_irq_valid_q;
    assign core_irq_source = core_irq_source_q;
    assign core_irq_level  = core_irq_level_q;
    assign irq             = |(event_status & event_enable);
endmodule : iep_top
